// file: core/fsk_tone_pkg.sv
// Shared constants for the FSK modem tone and demodulator control block
package fsk_tone_pkg;

   // ****************************************
   // Clock and reference timing
   // ****************************************
   localparam int unsigned MCLK_HZ     = 200_000_000;
   localparam int unsigned REF_HZ      = 1_000_000;
   localparam int unsigned REF_DIV     = MCLK_HZ / REF_HZ;
   localparam int unsigned PHASE_BITS  = 24;

   // Phase step per reference tick for a tone in Hz
   function automatic logic [PHASE_BITS-1:0] tone_inc(input longint unsigned f_hz);
      return PHASE_BITS'((f_hz * (64'd1 << PHASE_BITS) + REF_HZ / 2) / REF_HZ);
   endfunction

   // ****************************************
   // Tone frequencies
   // ****************************************
   localparam longint unsigned F_US_ORIG_MARK_HZ  = 1270;
   localparam longint unsigned F_US_ORIG_SPACE_HZ = 1070;
   localparam longint unsigned F_US_ANS_MARK_HZ   = 2225;
   localparam longint unsigned F_US_ANS_SPACE_HZ  = 2025;
   localparam longint unsigned F_INT_CH1_MARK_HZ  = 980;
   localparam longint unsigned F_INT_CH1_SPACE_HZ = 1180;
   localparam longint unsigned F_INT_CH2_MARK_HZ  = 1650;
   localparam longint unsigned F_INT_CH2_SPACE_HZ = 1850;
   localparam longint unsigned F_ECHO_OFF_HZ      = 2100;

   // Receive decision: pair midpoint period in mclk cycles
   localparam logic [19:0] THR_US_ORIG  = 20'(MCLK_HZ / ((F_US_ORIG_MARK_HZ + F_US_ORIG_SPACE_HZ) / 2));
   localparam logic [19:0] THR_US_ANS   = 20'(MCLK_HZ / ((F_US_ANS_MARK_HZ + F_US_ANS_SPACE_HZ) / 2));
   localparam logic [19:0] THR_INT_CH1  = 20'(MCLK_HZ / ((F_INT_CH1_MARK_HZ + F_INT_CH1_SPACE_HZ) / 2));
   localparam logic [19:0] THR_INT_CH2  = 20'(MCLK_HZ / ((F_INT_CH2_MARK_HZ + F_INT_CH2_SPACE_HZ) / 2));

   // Agreeing periods needed per receive rate
   localparam logic [1:0] AGREE_300 = 2'h3;
   localparam logic [1:0] AGREE_600 = 2'h2;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_TXDATA = 8'h08;
   localparam logic [7:0] OFS_BITDIV = 8'h0c;

   localparam int unsigned CTRL_STANDARD_US = 0;
   localparam int unsigned CTRL_ORIGINATE   = 1;
   localparam int unsigned CTRL_ECHO_OFF    = 2;
   localparam int unsigned CTRL_TX_ENABLE   = 3;
   localparam int unsigned CTRL_RATE_300    = 4;
   localparam int unsigned CTRL_LOOPBACK    = 5;
   localparam int unsigned CTRL_DEMOD_OFF   = 6;
   localparam logic [6:0]  CTRL_RESET       = 7'h13;

   localparam logic [15:0] BITDIV_RESET = 16'h0d05;   // 3333 ticks, 300 bit/s

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [7:0] SINE_MID    = 8'h80;

endpackage

// file: core/byte_stream_if.sv
// Valid/ready stream carrier between the modem's own modules
`timescale 1ns/100ps
`default_nettype none
interface byte_stream_if #(parameter int unsigned WIDTH = 8);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: core/stream_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module stream_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic      mclk,
   input  wire logic      sys_rst,
   byte_stream_if.snk     fill,
   byte_stream_if.src     drain
);
   localparam int unsigned AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("stream_fifo depth must be a power of two, at least 2");
   end
   if ($bits(fill.data) != WIDTH) begin : g_bad_width
      $error("stream_fifo width does not match its stream");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             full;
   logic             empty;

   // Honest full and empty from the wrap bit
   assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign empty       = (wr_ptr == rd_ptr);
   assign fill.ready  = !full;
   assign drain.valid = !empty;
   assign drain.data  = mem[rd_ptr[AW-1:0]];

   // Pointer advance on each accepted beat
   always_comb begin
      next_wr_ptr = wr_ptr + ((fill.valid && !full) ? 1'b1 : 1'b0);
      next_rd_ptr = rd_ptr + ((drain.ready && !empty) ? 1'b1 : 1'b0);
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   // Storage written on accept
   always_ff @(posedge mclk) begin
      if (fill.valid && !full) begin
         mem[wr_ptr[AW-1:0]] <= fill.data;
      end
   end
endmodule // stream_fifo
`default_nettype wire

// file: core/tone_synth.sv
// Phase-accumulator sine synthesiser stepped by the reference tick
`timescale 1ns/100ps
`default_nettype none
module tone_synth (
   input  wire logic                              mclk,
   input  wire logic                              sys_rst,
   input  wire logic                              ref_tick,
   input  wire logic [fsk_tone_pkg::PHASE_BITS-1:0] step,
   input  wire logic                              enable,
   output logic      [7:0]                        sample,
   output logic                                   square
);
   // One full sine period, offset binary
   localparam logic [7:0] SINE [32] = '{
      8'h80, 8'h99, 8'hb1, 8'hc7, 8'hda, 8'hea, 8'hf5, 8'hfd,
      8'hff, 8'hfd, 8'hf5, 8'hea, 8'hda, 8'hc7, 8'hb1, 8'h99,
      8'h80, 8'h67, 8'h4f, 8'h39, 8'h26, 8'h16, 8'h0b, 8'h03,
      8'h01, 8'h03, 8'h0b, 8'h16, 8'h26, 8'h39, 8'h4f, 8'h67};
   localparam int unsigned PB = fsk_tone_pkg::PHASE_BITS;

   logic [PB-1:0] phase;
   logic [PB-1:0] next_phase;
   logic [7:0]    next_sample;

   // Step never resets phase, so tone changes stay continuous
   always_comb begin
      next_phase  = ref_tick ? phase + step : phase;
      next_sample = enable ? SINE[phase[PB-1 -: 5]] : fsk_tone_pkg::SINE_MID;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         phase  <= '0;
         sample <= fsk_tone_pkg::SINE_MID;
         square <= 1'b0;
      end else begin
         phase  <= next_phase;
         sample <= next_sample;
         square <= phase[PB-1];
      end
   end
endmodule // tone_synth
`default_nettype wire

// file: core/fsk_modem_tone_control.sv
// FSK modem tone selection, transmit serialiser, demodulator and register slave
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module fsk_modem_tone_control #(
   parameter int unsigned FIFO_DEPTH = 8
) (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        rx_carrier,
   output logic [7:0]       tx_carrier,
   output logic             rx_data
);
   if (FIFO_DEPTH < 2) begin : g_bad_depth
      $error("FIFO_DEPTH must be at least 2");
   end

   // ****************************************
   // Declarations
   // ****************************************
   logic [7:0]  ref_cnt;
   logic [7:0]  next_ref_cnt;
   logic        ref_tick;
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        next_aw_held;
   logic        next_w_held;
   logic [7:0]  next_aw_addr;
   logic [31:0] next_w_data;
   logic [3:0]  next_w_strb;
   logic        next_bvalid;
   logic [1:0]  next_bresp;
   logic        next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;
   logic [6:0]  ctrl;
   logic [6:0]  next_ctrl;
   logic [15:0] bitdiv;
   logic [15:0] next_bitdiv;
   logic        wr_both;
   logic        wr_go;
   logic        wr_map;
   logic        rd_map;
   logic        standard_us;
   logic        originate;
   logic        echo_disable;
   logic        tx_enable;
   logic        rx_rate_300;
   logic        loopback_test;
   logic        demod_disable;
   logic [7:0]  tx_shift;
   logic [2:0]  tx_bitno;
   logic        tx_busy;
   logic [15:0] tx_timer;
   logic [7:0]  next_tx_shift;
   logic [2:0]  next_tx_bitno;
   logic        next_tx_busy;
   logic [15:0] next_tx_timer;
   logic        tx_bit;
   logic [23:0] tone_step;
   logic        tx_square;
   logic [1:0]  tx_pair;
   logic [1:0]  rx_pair;
   logic [19:0] rx_thr;
   logic        rx_sync1;
   logic        rx_sync2;
   logic        rx_prev;
   logic        rx_in;
   logic [19:0] per_cnt;
   logic        last_high;
   logic [1:0]  agree;
   logic [19:0] next_per_cnt;
   logic        next_last_high;
   logic [1:0]  next_agree;
   logic        next_rx_data;
   logic        rx_edge;
   logic        is_high;

   byte_stream_if #(.WIDTH(8)) push_s ();
   byte_stream_if #(.WIDTH(8)) pop_s ();

   assign standard_us   = ctrl[fsk_tone_pkg::CTRL_STANDARD_US];
   assign originate     = ctrl[fsk_tone_pkg::CTRL_ORIGINATE];
   assign echo_disable  = ctrl[fsk_tone_pkg::CTRL_ECHO_OFF];
   assign tx_enable     = ctrl[fsk_tone_pkg::CTRL_TX_ENABLE];
   assign rx_rate_300   = ctrl[fsk_tone_pkg::CTRL_RATE_300];
   assign loopback_test = ctrl[fsk_tone_pkg::CTRL_LOOPBACK];
   assign demod_disable = ctrl[fsk_tone_pkg::CTRL_DEMOD_OFF];

   // ****************************************
   // Reference tick divider
   // ****************************************
   // One-cycle tick at the 1 MHz reference rate
   always_comb begin
      ref_tick     = (ref_cnt == 8'(fsk_tone_pkg::REF_DIV - 1));
      next_ref_cnt = ref_tick ? 8'h00 : ref_cnt + 8'h01;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ref_cnt <= 8'h00;
      end else begin
         ref_cnt <= next_ref_cnt;
      end
   end

   // ****************************************
   // Register slave
   // ****************************************
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_both       = aw_held && w_held && !s_axi_bvalid;
   assign wr_map        = (aw_addr == fsk_tone_pkg::OFS_CTRL) || (aw_addr == fsk_tone_pkg::OFS_STATUS)
                          || (aw_addr == fsk_tone_pkg::OFS_TXDATA) || (aw_addr == fsk_tone_pkg::OFS_BITDIV);
   assign rd_map        = (s_axi_araddr == fsk_tone_pkg::OFS_CTRL)
                          || (s_axi_araddr == fsk_tone_pkg::OFS_STATUS)
                          || (s_axi_araddr == fsk_tone_pkg::OFS_TXDATA)
                          || (s_axi_araddr == fsk_tone_pkg::OFS_BITDIV);
   // Data writes wait for room in the FIFO
   assign push_s.valid  = wr_both && (aw_addr == fsk_tone_pkg::OFS_TXDATA) && w_strb[0];
   assign push_s.data   = w_data[7:0];
   assign wr_go         = wr_both && (!push_s.valid || push_s.ready);

   // Next values of the bus channels and the writable registers
   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid && !s_axi_bready;
      next_bresp   = s_axi_bresp;
      next_rvalid  = s_axi_rvalid && !s_axi_rready;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      next_ctrl    = ctrl;
      next_bitdiv  = bitdiv;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (wr_go) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = wr_map ? fsk_tone_pkg::RESP_OKAY : fsk_tone_pkg::RESP_SLVERR;
         if (aw_addr == fsk_tone_pkg::OFS_CTRL && w_strb[0]) begin
            next_ctrl = w_data[6:0];
         end
         if (aw_addr == fsk_tone_pkg::OFS_BITDIV) begin
            if (w_strb[0]) begin
               next_bitdiv[7:0] = w_data[7:0];
            end
            if (w_strb[1]) begin
               next_bitdiv[15:8] = w_data[15:8];
            end
         end
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = rd_map ? fsk_tone_pkg::RESP_OKAY : fsk_tone_pkg::RESP_SLVERR;
         unique case ({s_axi_araddr[7:2], 2'b00})
            fsk_tone_pkg::OFS_CTRL:   next_rdata = {25'h0, ctrl};
            fsk_tone_pkg::OFS_STATUS: next_rdata = {27'h0, !push_s.ready, !pop_s.valid,
                                                    tx_busy, tx_bit, rx_data};
            fsk_tone_pkg::OFS_BITDIV: next_rdata = {16'h0, bitdiv};
            default:                  next_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= fsk_tone_pkg::RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= fsk_tone_pkg::RESP_OKAY;
         ctrl         <= fsk_tone_pkg::CTRL_RESET;
         bitdiv       <= fsk_tone_pkg::BITDIV_RESET;
      end else begin
         aw_held      <= next_aw_held;
         w_held       <= next_w_held;
         aw_addr      <= next_aw_addr;
         w_data       <= next_w_data;
         w_strb       <= next_w_strb;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp  <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= next_rresp;
         ctrl         <= next_ctrl;
         bitdiv       <= next_bitdiv;
      end
   end

   // ****************************************
   // Transmit byte buffer and serialiser
   // ****************************************
   stream_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .fill    (push_s),
      .drain   (pop_s)
   );

   assign pop_s.ready = !tx_busy;
   // Idle line sends mark
   assign tx_bit      = tx_busy ? tx_shift[0] : 1'b1;

   // LSB first, one bit per bitdiv reference ticks
   always_comb begin
      next_tx_shift = tx_shift;
      next_tx_bitno = tx_bitno;
      next_tx_busy  = tx_busy;
      next_tx_timer = tx_timer;
      if (!tx_busy) begin
         if (pop_s.valid) begin
            next_tx_shift = pop_s.data;
            next_tx_bitno = 3'h0;
            next_tx_busy  = 1'b1;
            next_tx_timer = 16'h0;
         end
      end else if (ref_tick) begin
         if (tx_timer + 16'h1 >= bitdiv) begin
            next_tx_timer = 16'h0;
            next_tx_shift = {1'b1, tx_shift[7:1]};
            next_tx_bitno = tx_bitno + 3'h1;
            next_tx_busy  = (tx_bitno != 3'h7);
         end else begin
            next_tx_timer = tx_timer + 16'h1;
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_shift <= 8'hff;
         tx_bitno <= 3'h0;
         tx_busy  <= 1'b0;
         tx_timer <= 16'h0;
      end else begin
         tx_shift <= next_tx_shift;
         tx_bitno <= next_tx_bitno;
         tx_busy  <= next_tx_busy;
         tx_timer <= next_tx_timer;
      end
   end

   // ****************************************
   // Tone selection
   // ****************************************
   // Pair index: bit1 international, bit0 answer or channel 2
   assign tx_pair = {!standard_us, !originate};
   always_comb begin
      if (echo_disable && !standard_us && !originate && tx_bit) begin
         tone_step = fsk_tone_pkg::tone_inc(fsk_tone_pkg::F_ECHO_OFF_HZ);
      end else begin
         unique case ({tx_pair, tx_bit})
            3'b001:  tone_step = fsk_tone_pkg::tone_inc(fsk_tone_pkg::F_US_ORIG_MARK_HZ);
            3'b000:  tone_step = fsk_tone_pkg::tone_inc(fsk_tone_pkg::F_US_ORIG_SPACE_HZ);
            3'b011:  tone_step = fsk_tone_pkg::tone_inc(fsk_tone_pkg::F_US_ANS_MARK_HZ);
            3'b010:  tone_step = fsk_tone_pkg::tone_inc(fsk_tone_pkg::F_US_ANS_SPACE_HZ);
            3'b101:  tone_step = fsk_tone_pkg::tone_inc(fsk_tone_pkg::F_INT_CH1_MARK_HZ);
            3'b100:  tone_step = fsk_tone_pkg::tone_inc(fsk_tone_pkg::F_INT_CH1_SPACE_HZ);
            3'b111:  tone_step = fsk_tone_pkg::tone_inc(fsk_tone_pkg::F_INT_CH2_MARK_HZ);
            default: tone_step = fsk_tone_pkg::tone_inc(fsk_tone_pkg::F_INT_CH2_SPACE_HZ);
         endcase
      end
   end

   tone_synth u_synth (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .ref_tick (ref_tick),
      .step     (tone_step),
      .enable   (tx_enable),
      .sample   (tx_carrier),
      .square   (tx_square)
   );

   // ****************************************
   // Demodulator
   // ****************************************
   // Remote pair normally, own pair under self-test
   assign rx_pair = loopback_test ? tx_pair : {tx_pair[1], !tx_pair[0]};
   always_comb begin
      unique case (rx_pair)
         2'b00:   rx_thr = fsk_tone_pkg::THR_US_ORIG;
         2'b01:   rx_thr = fsk_tone_pkg::THR_US_ANS;
         2'b10:   rx_thr = fsk_tone_pkg::THR_INT_CH1;
         default: rx_thr = fsk_tone_pkg::THR_INT_CH2;
      endcase
   end

   // Two-stage synchroniser on the carrier pin
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_sync1 <= 1'b0;
         rx_sync2 <= 1'b0;
      end else begin
         rx_sync1 <= rx_carrier;
         rx_sync2 <= rx_sync1;
      end
   end

   assign rx_in   = loopback_test ? tx_square : rx_sync2;
   assign rx_edge = rx_in && !rx_prev;
   assign is_high = (per_cnt < rx_thr);

   // Period measured rising edge to rising edge, decision after agreement
   always_comb begin
      next_per_cnt   = (per_cnt == 20'hfffff) ? per_cnt : per_cnt + 20'h1;
      next_last_high = last_high;
      next_agree     = agree;
      next_rx_data   = rx_data;
      if (demod_disable) begin
         next_per_cnt = 20'h0;
         next_agree   = 2'h0;
      end else if (rx_edge) begin
         next_per_cnt   = 20'h0;
         next_last_high = is_high;
         next_agree     = (is_high != last_high) ? 2'h1
                        : (agree == 2'h3) ? agree : agree + 2'h1;
         if (next_agree >= (rx_rate_300 ? fsk_tone_pkg::AGREE_300
                                        : fsk_tone_pkg::AGREE_600)) begin
            // US mark is the higher tone, international mark the lower
            next_rx_data = standard_us ? is_high : !is_high;
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_prev   <= 1'b0;
         per_cnt   <= 20'h0;
         last_high <= 1'b0;
         agree     <= 2'h0;
         rx_data   <= 1'b1;
      end else begin
         rx_prev   <= rx_in;
         per_cnt   <= next_per_cnt;
         last_high <= next_last_high;
         agree     <= next_agree;
         rx_data   <= next_rx_data;
      end
   end
endmodule // fsk_modem_tone_control
`default_nettype wire

// file: testbench/fsk_line_model.sv
// Line-side model: limited receive carrier square wave
`timescale 1ns/100ps
`default_nettype none
module fsk_line_model (
   input  wire logic        mclk,
   input  wire logic        on,
   input  wire logic [19:0] half,
   output logic             rx_carrier = 1'h0
);
   logic [19:0] cnt = 20'h0;
   // Even duty square, idles low when off
   always @(posedge mclk) begin
      cnt <= (cnt == half) ? 20'h0 : cnt + 20'h1;
      if (cnt == half) rx_carrier <= on & ~rx_carrier;
   end
endmodule // fsk_line_model
`default_nettype wire

// file: testbench/fsk_tone_sva.sv
// Port checks for the tone control block
`timescale 1ns/100ps
`default_nettype none
module fsk_tone_sva (
   input wire logic       mclk,
   input wire logic       sys_rst,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   input wire logic       rx_data,
   input wire logic [7:0] tx_carrier
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("rvalid dropped");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   r_answer_a: assert property (ar_taken |=> s_axi_rvalid)
      else $error("read answer late");
   r_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
      else $error("read answer unasked");
   reset_out_a: assert property ($fell(sys_rst) |-> rx_data && tx_carrier == 8'h80)
      else $error("outputs wrong after reset");
   phase_step_a: assert property (tx_carrier != 8'h80 && $past(tx_carrier) != 8'h80
      |-> 8'(tx_carrier + 8'h19 - $past(tx_carrier)) <= 8'h32) else $error("sine jumped");
endmodule // fsk_tone_sva
bind fsk_modem_tone_control fsk_tone_sva chk_u (.mclk, .sys_rst, .s_axi_awready, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .rx_data, .tx_carrier);
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the FSK modem tone control block
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic mclk = 1'h0, sys_rst = 1'h1, line_on = 1'h0, rx_carrier, rx_data, s_axi_rready = 1'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, tx_carrier, prev, peak;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, got;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   int fail_count = 0, total_checks = 0, n, seed = 32'hc106ccd4;
   always #2.5 mclk = ~mclk;
   fsk_modem_tone_control #(.FIFO_DEPTH(8)) dut_u (.*);
   fsk_line_model line_u (.mclk, .on(line_on), .half(20'h63), .rx_carrier);
   function automatic int half_cyc(int hz); return fsk_tone_pkg::MCLK_HZ / 2 / hz; endfunction
   task automatic chk(input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t: %h vs %h", $time, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'h1;
      end while (!(s_axi_bvalid && s_axi_bready));
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      {s_axi_araddr, s_axi_arvalid} <= {a, 1'h1};
      do begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'h1;
      end while (!(s_axi_rvalid && s_axi_rready));
      {got, resp} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'h0;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Registers, fill and drain, echo tone, silence
   initial begin
      repeat (12) @(posedge mclk);
      {sys_rst, line_on} <= 2'h1;
      rd(8'h00);
      chk(32'h13, got);
      rd(8'h10);
      chk(32'h2, {got[29:0], resp});
      wr(8'h04, 32'h0);
      chk(32'h0, {30'h0, resp});
      for (int k = 0; k < 4; k++) begin
         n = $random(seed);
         wr(8'h00, n);
         rd(8'h00);
         chk({25'h0, n[6:0]}, got);
         wr(8'h0c, n | 1);
         rd(8'h0c);
         chk({16'h0, n[15:0] | 16'h1}, got);
      end
      wr(8'h00, 32'h1b);
      wr(8'h0c, 32'h1);
      repeat (9) wr(8'h08, $random(seed));
      rd(8'h04);
      chk(32'h14, got & 32'h1c);
      repeat (15000) @(posedge mclk);
      rd(8'h04);
      chk(32'hb, got & 32'h1f);
      wr(8'h00, 32'h5c);
      prev = tx_carrier;
      @(posedge mclk);
      // Wait for a zero crossing, then time a quarter period to the peak
      for (n = 0; n < 60000 && !(prev < 8'h80 && tx_carrier >= 8'h80)
           && !(prev > 8'h80 && tx_carrier <= 8'h80); n++) begin
         prev = tx_carrier;
         @(posedge mclk);
      end
      peak = prev[7] ? 8'h01 : 8'hff;
      for (n = 0; tx_carrier !== peak && n < 60000; n++) @(posedge mclk);
      chk(32'h1, {31'h0, n > half_cyc(2100) / 2 - 400 && n < half_cyc(2100) / 2 + 400});
      rd(8'h04);
      chk(32'h1, {31'h0, got[0]});
      wr(8'h00, 32'h14);
      n = 0;
      repeat (800) @(posedge mclk) n += (tx_carrier !== 8'h80);
      chk(32'h0, n);
      rd(8'h04);
      chk(32'h0, {31'h0, got[0]});
      report_and_stop();
   end
   // Hang guard
   initial begin
      #600_000;
      fail_count++;
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
